// >>> src/iprio_pkg.sv
// package: register map, field layout and reset values of the priority bank
package iprio_pkg;
   // ==========================================================================
   // geometry
   localparam int unsigned NUM_REGS    = 6;
   localparam int unsigned NUM_SRC     = 16;
   localparam int unsigned PRIO_W      = 3;
   localparam int unsigned REG_W       = 16;
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned IDX_W       = 3;

   typedef logic [PRIO_W-1:0] iprio_level_t;
   typedef logic [REG_W-1:0]  iprio_word_t;

   // ==========================================================================
   // byte offsets, one aligned word each
   localparam logic [ADDR_W-1:0] OFS_UART2_INT2_TIMER5 = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CAN_SPI2          = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DMA3              = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DMA4_PARPORT      = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_ENCODER_PWM       = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FAULT_RTC_DMA5    = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CFG               = 8'h18;

   // ==========================================================================
   // field positions (low bit of each field)
   localparam int unsigned POS_HI  = 12;
   localparam int unsigned POS_MID = 8;
   localparam int unsigned POS_LO4 = 4;
   localparam int unsigned POS_LO0 = 0;

   // implemented-bit masks per register, everything else reads zero
   localparam iprio_word_t MASK_R0 = 16'h7777;
   localparam iprio_word_t MASK_R1 = 16'h7777;
   localparam iprio_word_t MASK_R2 = 16'h0007;
   localparam iprio_word_t MASK_R3 = 16'h0770;
   localparam iprio_word_t MASK_R4 = 16'h0770;
   localparam iprio_word_t MASK_R5 = 16'h7770;

   // ==========================================================================
   // reset values: level 4 in every implemented field
   localparam iprio_level_t PRIO_RST  = 3'h4;
   localparam iprio_level_t PRIO_OFF  = 3'h0;
   localparam iprio_word_t  RST_ALL4  = 16'h4444;
   localparam logic         CFG_CAN_RST = 1'b1;
endpackage : iprio_pkg

// >>> src/iprio_reg_if.sv
// interface: write strobes and stored words between bus slave and register bank
`timescale 1ns/1ps
interface iprio_reg_if;
   logic                                          wr_en;
   logic [iprio_pkg::IDX_W-1:0]                   wr_idx;
   iprio_pkg::iprio_word_t                        wr_data;
   iprio_pkg::iprio_word_t [iprio_pkg::NUM_REGS-1:0] words;

   modport slave (output wr_en, output wr_idx, output wr_data, input words);
   modport bank  (input wr_en, input wr_idx, input wr_data, output words);
endinterface : iprio_reg_if

// >>> src/iprio_bank.sv
// priority register bank: masked storage with level-4 reset
`timescale 1ns/1ps
module iprio_bank (
   input  wire logic  i_clk,
   input  wire logic  i_srst,
   iprio_reg_if.bank  rif
);
   localparam iprio_pkg::iprio_word_t MASKS [iprio_pkg::NUM_REGS] = '{
      iprio_pkg::MASK_R0, iprio_pkg::MASK_R1, iprio_pkg::MASK_R2,
      iprio_pkg::MASK_R3, iprio_pkg::MASK_R4, iprio_pkg::MASK_R5};

   // ==========================================================================
   // one word per register
   genvar g;
   generate
      for (g = 0; g < iprio_pkg::NUM_REGS; g++) begin : g_word
         iprio_pkg::iprio_word_t word_r;
         wire sel = rif.wr_en && (int'(rif.wr_idx) == g);
         always_ff @(posedge i_clk) begin
            if (i_srst) begin
               word_r <= iprio_pkg::RST_ALL4 & MASKS[g];
            end else if (sel) begin
               word_r <= rif.wr_data & MASKS[g];
            end
         end
         assign rif.words[g] = word_r;
      end
   endgenerate
endmodule : iprio_bank

// >>> src/iprio_top.sv
// top: AHB-Lite slave and priority register bank for sixteen interrupt sources
`timescale 1ns/1ps
module iprio_top #(
   parameter bit HAS_CAN = 1'b1
) (
   input  wire logic                                     i_clk,
   input  wire logic                                     i_srst,
   // ahb-lite slave
   input  wire logic                                     i_hsel,
   input  wire logic [31:0]                              i_haddr,
   input  wire logic [1:0]                               i_htrans,
   input  wire logic                                     i_hwrite,
   input  wire logic [2:0]                               i_hsize,
   input  wire logic [31:0]                              i_hwdata,
   input  wire logic                                     i_hready,
   output logic      [31:0]                              o_hrdata,
   output logic                                          o_hreadyout,
   output logic                                          o_hresp,
   // source requests in, gated requests and levels out
   input  wire logic [iprio_pkg::NUM_SRC-1:0]            i_src_req,
   output logic      [iprio_pkg::NUM_SRC-1:0]            o_src_req,
   output logic      [iprio_pkg::NUM_SRC*iprio_pkg::PRIO_W-1:0] o_src_level
);
   // ==========================================================================
   // source order on o_src_req / o_src_level:
   // 0 serial2_tx 1 serial2_rx 2 ext_irq2 3 timer_five 4 can_event 5 can_rx_ready
   // 6 spi_two_event 7 spi_two_error 8 dma_ch3 9 dma_ch4 10 parallel_port
   // 11 encoder_one 12 motor_pwm_one 13 pwm_fault_a 14 rtc_alarm 15 dma_ch5

   iprio_reg_if rif ();

   iprio_bank u_bank (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .rif    (rif)
   );

   // ==========================================================================
   // address phase capture
   logic                         wr_pend_r;
   logic                         rd_pend_r;
   logic [iprio_pkg::ADDR_W-1:0] addr_r;
   logic                         cfg_can_r;
   logic [31:0]                  rdata_r;

   wire                         xfer_ok = i_hsel && i_hready && i_htrans[1];
   wire [iprio_pkg::ADDR_W-1:0] a_ph    = i_haddr[iprio_pkg::ADDR_W-1:0];

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= '0;
      end else begin
         wr_pend_r <= xfer_ok && i_hwrite;
         rd_pend_r <= xfer_ok && !i_hwrite;
         if (xfer_ok) begin
            addr_r <= a_ph;
         end
      end
   end

   // ==========================================================================
   // address decode
   wire                         bank_hit = (addr_r[1:0] == 2'h0) &&
                                           (addr_r < iprio_pkg::OFS_CFG);
   wire                         cfg_hit  = (addr_r == iprio_pkg::OFS_CFG);
   wire [iprio_pkg::IDX_W-1:0]  idx      = addr_r[iprio_pkg::IDX_W+1:2];

   assign rif.wr_en   = wr_pend_r && bank_hit;
   assign rif.wr_idx  = idx;
   assign rif.wr_data = i_hwdata[iprio_pkg::REG_W-1:0];

   // ==========================================================================
   // config register: can module present
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cfg_can_r <= iprio_pkg::CFG_CAN_RST;
      end else if (wr_pend_r && cfg_hit) begin
         cfg_can_r <= i_hwdata[0];
      end
   end

   wire can_present = HAS_CAN && cfg_can_r;

   // ==========================================================================
   // read data, muxed in the data phase one cycle behind the address phase and held in rdata_r
   wire [31:0] rd_mux = bank_hit ? {16'h0000, rif.words[idx]} :
                        cfg_hit  ? {31'h00000000, cfg_can_r}  : 32'h00000000;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rdata_r <= '0;
      end else if (xfer_ok && !i_hwrite) begin
         rdata_r <= '0;
      end else if (rd_pend_r) begin
         rdata_r <= rd_mux;
      end
   end

   // read data out in the data phase: combinational from stored words
   assign o_hrdata    = rd_pend_r ? rd_mux : rdata_r;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

   // ==========================================================================
   // field extraction per source
   wire iprio_pkg::iprio_word_t w0 = rif.words[0];
   wire iprio_pkg::iprio_word_t w1 = rif.words[1];
   wire iprio_pkg::iprio_word_t w2 = rif.words[2];
   wire iprio_pkg::iprio_word_t w3 = rif.words[3];
   wire iprio_pkg::iprio_word_t w4 = rif.words[4];
   wire iprio_pkg::iprio_word_t w5 = rif.words[5];

   iprio_pkg::iprio_level_t lvl [iprio_pkg::NUM_SRC];

   assign lvl[0]  = w0[iprio_pkg::POS_HI  +: iprio_pkg::PRIO_W];
   assign lvl[1]  = w0[iprio_pkg::POS_MID +: iprio_pkg::PRIO_W];
   assign lvl[2]  = w0[iprio_pkg::POS_LO4 +: iprio_pkg::PRIO_W];
   assign lvl[3]  = w0[iprio_pkg::POS_LO0 +: iprio_pkg::PRIO_W];
   assign lvl[4]  = can_present ? w1[iprio_pkg::POS_HI +: iprio_pkg::PRIO_W]
                                : iprio_pkg::PRIO_OFF;
   assign lvl[5]  = can_present ? w1[iprio_pkg::POS_MID +: iprio_pkg::PRIO_W]
                                : iprio_pkg::PRIO_OFF;
   assign lvl[6]  = w1[iprio_pkg::POS_LO4 +: iprio_pkg::PRIO_W];
   assign lvl[7]  = w1[iprio_pkg::POS_LO0 +: iprio_pkg::PRIO_W];
   assign lvl[8]  = w2[iprio_pkg::POS_LO0 +: iprio_pkg::PRIO_W];
   assign lvl[9]  = w3[iprio_pkg::POS_MID +: iprio_pkg::PRIO_W];
   assign lvl[10] = w3[iprio_pkg::POS_LO4 +: iprio_pkg::PRIO_W];
   assign lvl[11] = w4[iprio_pkg::POS_MID +: iprio_pkg::PRIO_W];
   assign lvl[12] = w4[iprio_pkg::POS_LO4 +: iprio_pkg::PRIO_W];
   assign lvl[13] = w5[iprio_pkg::POS_HI  +: iprio_pkg::PRIO_W];
   assign lvl[14] = w5[iprio_pkg::POS_MID +: iprio_pkg::PRIO_W];
   assign lvl[15] = w5[iprio_pkg::POS_LO4 +: iprio_pkg::PRIO_W];

   // ==========================================================================
   // per-source level and gated request toward arbitration
   genvar s;
   generate
      for (s = 0; s < iprio_pkg::NUM_SRC; s++) begin : g_src
         // level is used as is: value n is priority n
         assign o_src_level[s*iprio_pkg::PRIO_W +: iprio_pkg::PRIO_W] = lvl[s];
         assign o_src_req[s] = i_src_req[s] && (lvl[s] != iprio_pkg::PRIO_OFF);
      end
   endgenerate
endmodule : iprio_top

// >>> dv/iprio_top_assertions.sv
// checker: bus response, read masking, level mapping and request gating
`timescale 1ns/1ps
module iprio_top_checker (
   input wire logic        i_clk,
   input wire logic        i_srst,
   input wire logic        i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0]  i_htrans,
   input wire logic        i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic        i_hready,
   input wire logic [31:0] o_hrdata,
   input wire logic        o_hreadyout,
   input wire logic        o_hresp,
   input wire logic [15:0] i_src_req,
   input wire logic [15:0] o_src_req,
   input wire logic [47:0] o_src_level
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // ==================
   // helpers
   logic [15:0] lvl_nz;
   logic [15:0] wd_q;
   logic        wr_dp;
   logic        cfg_wr;
   logic        can_q;
   always_comb begin
      for (int s = 0; s < 16; s++) lvl_nz[s] = |o_src_level[3*s +: 3];
   end
   always_ff @(posedge i_clk) begin
      wd_q  <= i_hwdata[15:0];
      wr_dp <= !i_srst && i_hsel && i_hready && i_htrans[1] && i_hwrite;
      cfg_wr <= !i_srst && i_hsel && i_hready && i_htrans[1] && i_hwrite &&
                i_haddr[7:0] == 8'h18;
      if (i_srst) begin
         can_q <= 1'b1;
      end else if (cfg_wr) begin
         can_q <= i_hwdata[0];
      end
   end
   // address phase then data phase of a write
   sequence s_wr(logic [7:0] ofs);
      i_hsel && i_hready && i_htrans[1] && i_hwrite && i_haddr[7:0] == ofs ##1 1'b1;
   endsequence
   sequence s_rd_hole;
      i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr[7:0] >= 8'h1c;
   endsequence
   // ==================
   // properties
   chk_resp_okay: assert property (o_hresp == 1'b0 && o_hreadyout == 1'b1)
      else $error("bad response");
   chk_gaps_zero: assert property ((o_hrdata & 32'hffff8888) == 32'h0)
      else $error("unassigned bits nonzero");
   chk_req_gate: assert property (o_src_req == (i_src_req & lvl_nz))
      else $error("request gating wrong");
   chk_reset_four: assert property ($fell(i_srst) |-> o_src_level == {16{3'h4}})
      else $error("reset levels wrong");
   chk_hole_reads: assert property (s_rd_hole |=> o_hrdata == 32'h0)
      else $error("unmapped read nonzero");
   chk_ser_levels: assert property (s_wr(8'h00) |=> o_src_level[11:0] ==
      {wd_q[2:0], wd_q[6:4], wd_q[10:8], wd_q[14:12]}) else $error("reg0 levels");
   chk_can_levels: assert property (s_wr(8'h04) |=> o_src_level[23:12] ==
      {wd_q[2:0], wd_q[6:4], can_q ? wd_q[10:8] : 3'h0, can_q ? wd_q[14:12] : 3'h0})
      else $error("reg1 levels");
   chk_can_off: assert property (!can_q |-> o_src_level[17:12] == 6'h00)
      else $error("can levels not forced off");
   chk_dma3_level: assert property (s_wr(8'h08) |=> o_src_level[26:24] == wd_q[2:0])
      else $error("reg2 level");
   chk_dma4_pport: assert property (s_wr(8'h0c) |=> o_src_level[32:27] ==
      {wd_q[6:4], wd_q[10:8]}) else $error("reg3 levels");
   chk_enc_pwm: assert property (s_wr(8'h10) |=> o_src_level[38:33] ==
      {wd_q[6:4], wd_q[10:8]}) else $error("reg4 levels");
   chk_fault_rtc: assert property (s_wr(8'h14) |=> o_src_level[47:39] ==
      {wd_q[6:4], wd_q[10:8], wd_q[14:12]}) else $error("reg5 levels");
   chk_levels_hold: assert property (!wr_dp |=> $stable(o_src_level))
      else $error("levels moved without write");
endmodule : iprio_top_checker

// >>> dv/tb.sv
// testbench: bus access, readback and level outputs of the priority bank
`timescale 1ns/1ps
module tb;
   logic        i_clk = 1'b0, i_srst = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0;
   logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
   logic [1:0]  i_htrans = 2'h0;
   logic [15:0] i_src_req = 16'hffff, o_src_req;
   logic [47:0] o_src_level;
   logic        o_hreadyout, o_hresp;
   int          n_errors = 0, n_checks = 0, cyc = 0;
   logic        can_on = 1'b1;
   iprio_pkg::iprio_word_t mdl [6];
   localparam iprio_pkg::iprio_word_t MSK [6] = '{iprio_pkg::MASK_R0, iprio_pkg::MASK_R1,
      iprio_pkg::MASK_R2, iprio_pkg::MASK_R3, iprio_pkg::MASK_R4, iprio_pkg::MASK_R5};
   localparam int RIX [16] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 3, 3, 4, 4, 5, 5, 5};
   localparam int POS [16] = '{12, 8, 4, 0, 12, 8, 4, 0, 0, 8, 4, 8, 4, 12, 8, 4};
   localparam logic [7:0] HOLE [3] = '{8'h1c, 8'h02, 8'h40};
   always #5 i_clk = ~i_clk;
   iprio_top iprio_top_inst (.i_clk(i_clk), .i_srst(i_srst), .i_hsel(i_hsel),
      .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
      .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_src_req(i_src_req),
      .o_src_req(o_src_req), .o_src_level(o_src_level));
   // ==================
   // bus and compare tasks
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_hwrite <= wr;
      i_haddr <= {24'h0, a};
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= wd;
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      rd = o_hrdata;
   endtask : ahb
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic chk_outs();
      logic [47:0] lv;
      logic [15:0] rq;
      #1;
      for (int s = 0; s < 16; s++) begin
         lv[3*s +: 3] = mdl[RIX[s]][POS[s] +: 3];
         if (!can_on && (s == 4 || s == 5)) lv[3*s +: 3] = 3'h0;
         rq[s] = i_src_req[s] & (lv[3*s +: 3] != 3'h0);
      end
      chk(o_src_level, lv, "levels");
      chk({32'h0, o_src_req}, {32'h0, rq}, "requests");
      @(posedge i_clk);
   endtask : chk_outs
   task automatic rd_all();
      logic [31:0] rd;
      for (int i = 0; i < 6; i++) begin
         ahb(1'b0, 8'(4*i), 32'h0, rd);
         chk({16'h0, rd}, {32'h0, mdl[i]}, "readback");
      end
   endtask : rd_all
   // ==================
   // scenarios
   task automatic t_reset();
      logic [31:0] rd;
      for (int i = 0; i < 6; i++) mdl[i] = iprio_pkg::RST_ALL4 & MSK[i];
      can_on = 1'b1;
      chk_outs();
      rd_all();
      ahb(1'b0, iprio_pkg::OFS_CFG, 32'h0, rd);
      chk({16'h0, rd}, {47'h0, iprio_pkg::CFG_CAN_RST}, "cfg reset");
   endtask : t_reset
   task automatic t_fields();
      logic [31:0] wd, rd;
      for (int k = 0; k < 8; k++) begin
         i_src_req <= 16'h5a5a ^ 16'(k * 16'h1111);
         for (int i = 0; i < 6; i++) begin
            wd = {16'hffff, 1'b1, 3'(k+i), 1'b1, 3'(k+i+1), 1'b1, 3'(k+i+2), 1'b1, 3'(k+i+3)};
            ahb(1'b1, 8'(4*i), wd, rd);
            mdl[i] = wd[15:0] & MSK[i];
         end
         chk_outs();
         rd_all();
      end
   endtask : t_fields
   task automatic t_holes();
      logic [31:0] rd;
      foreach (HOLE[j]) begin
         ahb(1'b1, HOLE[j], 32'hffffffff, rd);
         ahb(1'b0, HOLE[j], 32'h0, rd);
         chk({16'h0, rd}, 48'h0, "unmapped read");
      end
      chk_outs();
   endtask : t_holes
   task automatic t_nocan();
      logic [31:0] rd;
      i_src_req <= 16'hffff;
      ahb(1'b1, iprio_pkg::OFS_CFG, 32'h0, rd);
      can_on = 1'b0;
      ahb(1'b1, iprio_pkg::OFS_CAN_SPI2, 32'h00007654, rd);
      mdl[1] = 16'h7654 & MSK[1];
      chk_outs();
      rd_all();
      ahb(1'b0, iprio_pkg::OFS_CFG, 32'h0, rd);
      chk({16'h0, rd}, 48'h0, "cfg off");
      ahb(1'b1, iprio_pkg::OFS_CFG, 32'h1, rd);
      can_on = 1'b1;
      chk_outs();
      ahb(1'b1, iprio_pkg::OFS_CFG, 32'h0, rd);
      can_on = 1'b0;
   endtask : t_nocan
   task automatic t_rerst();
      i_srst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      t_reset();
   endtask : t_rerst
   task automatic end_of_test();
      if (n_errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (20) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      t_reset();
      t_fields();
      t_holes();
      t_nocan();
      t_rerst();
      end_of_test();
   end
endmodule : tb
bind iprio_top iprio_top_checker iprio_top_checker_inst (.i_clk(i_clk), .i_srst(i_srst),
   .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
   .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
   .o_hresp(o_hresp), .i_src_req(i_src_req), .o_src_req(o_src_req),
   .o_src_level(o_src_level));
